// ===== logic/rasw_pkg.sv
// package: register map, field positions and timing of the aux sensor block
package rasw_pkg;
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_IRQ_STAT1  = 6'h03;
  localparam logic [5:0] IDX_IRQ_STAT2  = 6'h04;
  localparam logic [5:0] IDX_IRQ_EN2    = 6'h06;
  localparam logic [5:0] IDX_OP_CTRL    = 6'h07;
  localparam logic [5:0] IDX_CONV_CFG   = 6'h0f;
  localparam logic [5:0] IDX_CONV_VAL   = 6'h11;
  localparam logic [5:0] IDX_TS_CTRL    = 6'h12;
  localparam logic [5:0] IDX_TV_OFFS    = 6'h13;
  localparam logic [5:0] IDX_WT_EXP     = 6'h14;
  localparam logic [5:0] IDX_WT_MANT_HI = 6'h15;
  localparam logic [5:0] IDX_WT_MANT_LO = 6'h16;
  localparam logic [5:0] IDX_WT_VAL_HI  = 6'h17;
  localparam logic [5:0] IDX_WT_VAL_LO  = 6'h18;
  localparam logic [5:0] IDX_BAT_THR    = 6'h1a;
  localparam logic [5:0] IDX_BAT_LVL    = 6'h1b;

  // field positions
  localparam int BIT_WAKE_IRQ  = 3;    // in status 2 and enable 2
  localparam int BIT_BAT_IRQ   = 2;
  localparam int BIT_EN_BAT    = 6;    // in operating control
  localparam int BIT_EN_WAKE   = 5;
  localparam int BIT_CONV_GO   = 7;    // start / done in converter config
  localparam logic [2:0] SEL_TEMP = 3'h0;

  // reset values and low reading run length
  localparam logic [7:0] RST_TS_CTRL = 8'h20;
  localparam logic [7:0] RST_TV_OFFS = 8'h00;
  localparam logic [4:0] RST_BAT_THR = 5'h14;
  localparam logic [4:0] RST_WT_EXP  = 5'h03;
  localparam logic [2:0] LOW_RUN_NEEDED = 3'h4;

  // timing
  localparam int CLK_KHZ        = 10000;
  localparam int T_CONV_US      = 350;
  localparam int T_MEAS_US      = 250;
  localparam int T_BAT_PERIOD_MS = 1000;
  localparam int CONV_CYC = (T_CONV_US * CLK_KHZ + 999) / 1000;
  localparam int MEAS_CYC = (T_MEAS_US * CLK_KHZ + 999) / 1000;
  localparam int BAT_PERIOD_CYC = T_BAT_PERIOD_MS * CLK_KHZ;
  localparam int WT_PRE_SHIFT = 5;     // 32 slow ticks per unit

  // temperature sensor control fields
  typedef struct packed {
    logic [1:0] range;
    logic       shift_en;
    logic       trim_en;
    logic [1:0] trim;
    logic [1:0] vbg_trim;
  } rasw_ts_ctrl_s;
endpackage

// ===== logic/rasw_top.sv
// rasw_top: temperature readout, battery monitor and wake timer with apb
// Operation
// (RULE1) sensor powers up when selected, no enable
// (RULE2) host selects sensor, ref, range, offset, converts
// (RULE3) range field picks span and step size
// (RULE4) shift off gives absolute test mode; resets on
// (RULE5) offset enable adds offset to result
// (RULE6) trim enable drives trim into analog sensor
// (RULE7) host scales result by step plus range floor
// (RULE8) level below threshold raises enabled interrupt
// (RULE9) host reads both status registers after interrupt
// (RULE10) monitor runs only enabled; level always readable
// (RULE11) level is 5-bit code, 50 mV steps
// (RULE12) monitor powered each second for 250 us
// (RULE13) four consecutive low readings before interrupt
// (RULE14) monitor in sleep enables slow oscillator
// (RULE15) wake timer runs on slow clock, also asleep
// (RULE16) armed on sleep entry, interrupts on expiry
// (RULE17) period is 32 times mantissa times 2^exp
// (RULE18) live 16-bit count readable in two bytes
// (RULE19) start bit reads 0 busy, 1 done; 350 us
// (RULE20) wake interrupt pulls line low, starts crystal
// (RULE21) line held until status read, read clears
`timescale 1ns/1ns
module rasw_top #(
  parameter int BAT_PERIOD = rasw_pkg::BAT_PERIOD_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // analog converter side
  input  wire logic [7:0]  conv_sample,
  input  wire logic        test_bus_temp_sel,
  output logic             conv_power,
  output logic             temp_sensor_enable,
  output logic [1:0]       thermal_range,
  output logic             thermal_shift_enable,
  output logic [1:0]       sensor_trim,
  output logic [1:0]       bandgap_trim,
  // battery monitor side
  input  wire logic [4:0]  battery_code,
  output logic             battery_monitor_power,
  // chip state and slow clock
  input  wire logic        sleep_active,
  input  wire logic        lf_tick,
  output logic             lf_osc_enable,
  output logic             xtal_enable,
  output logic             host_interrupt_n
);

  ////////////////////////////////////////////////////////////////////////
  // bus decode
  logic [5:0]  idx;          // word index
  logic        mapped;       // address hits a register
  logic        acc;          // access phase completes this edge
  logic        wr;           // register write this edge
  logic [7:0]  wd;           // write byte
  logic [7:0]  rd;           // read byte before registering

  // register state
  rasw_pkg::rasw_ts_ctrl_s ts_ff, nxt_ts;
  logic [7:0]  tvoffs_ff, nxt_tvoffs;        // digital offset
  logic [4:0]  thr_ff, nxt_thr;              // battery threshold
  logic [7:0]  irq_en_ff, nxt_irq_en;        // interrupt enables
  logic [7:0]  op_ff, nxt_op;                // operating control
  logic [2:0]  sel_ff, nxt_sel;              // converter input select
  logic [1:0]  ref_ff, nxt_ref;              // converter reference
  logic [4:0]  wexp_ff, nxt_wexp;            // wake exponent
  logic [15:0] wman_ff, nxt_wman;            // wake mantissa
  logic [7:0]  prdata_ff, nxt_prdata;
  logic        err_ff, nxt_err;

  assign idx    = paddr[7:2];
  assign acc    = psel & penable;
  assign wr     = acc & pwrite;
  assign wd     = pwdata[7:0];
  // every access completes one cycle after setup
  assign pready  = acc;
  assign pslverr = acc & err_ff;
  assign prdata  = {24'h000000, prdata_ff};

  // core state
  logic        busy_ff, nxt_busy;            // conversion in flight
  logic [11:0] ccnt_ff, nxt_ccnt;
  logic [7:0]  cval_ff, nxt_cval;
  logic [23:0] bcnt_ff, nxt_bcnt;            // battery period counter
  logic [4:0]  lvl_ff, nxt_lvl;
  logic [2:0]  run_ff, nxt_run;              // consecutive low readings
  logic        wrun_ff, nxt_wrun;            // wake timer armed
  logic        slp_ff, nxt_slp;              // sleep seen last cycle
  logic [36:0] pre_ff, nxt_pre;              // slow-tick prescaler
  logic [15:0] wtv_ff, nxt_wtv;
  logic        fbat_ff, nxt_fbat;            // pending low battery
  logic        fwak_ff, nxt_fwak;            // pending wake expiry

  ////////////////////////////////////////////////////////////////////////
  // read mux, computed in setup so data comes from a flip-flop
  always_comb begin
    mapped = 1'b1;
    rd     = 8'h00;
    if (paddr[11:8] != 4'h0 || paddr[1:0] != 2'h0) begin
      mapped = 1'b0;
    end else if (idx == rasw_pkg::IDX_IRQ_STAT1) begin
      rd = 8'h00;                            // no sources here
    end else if (idx == rasw_pkg::IDX_IRQ_STAT2) begin
      rd[rasw_pkg::BIT_WAKE_IRQ] = fwak_ff;
      rd[rasw_pkg::BIT_BAT_IRQ]  = fbat_ff;
    end else if (idx == rasw_pkg::IDX_IRQ_EN2) begin
      rd = irq_en_ff;
    end else if (idx == rasw_pkg::IDX_OP_CTRL) begin
      rd = op_ff;
    end else if (idx == rasw_pkg::IDX_CONV_CFG) begin
      rd = {~busy_ff, sel_ff, ref_ff, 2'h0}; // see (RULE19)
    end else if (idx == rasw_pkg::IDX_CONV_VAL) begin
      rd = cval_ff;
    end else if (idx == rasw_pkg::IDX_TS_CTRL) begin
      rd = ts_ff;
    end else if (idx == rasw_pkg::IDX_TV_OFFS) begin
      rd = tvoffs_ff;
    end else if (idx == rasw_pkg::IDX_WT_EXP) begin
      rd = {3'h0, wexp_ff};
    end else if (idx == rasw_pkg::IDX_WT_MANT_HI) begin
      rd = wman_ff[15:8];
    end else if (idx == rasw_pkg::IDX_WT_MANT_LO) begin
      rd = wman_ff[7:0];
    end else if (idx == rasw_pkg::IDX_WT_VAL_HI) begin
      rd = wtv_ff[15:8];                     // see (RULE18)
    end else if (idx == rasw_pkg::IDX_WT_VAL_LO) begin
      rd = wtv_ff[7:0];                      // see (RULE18)
    end else if (idx == rasw_pkg::IDX_BAT_THR) begin
      rd = {3'h0, thr_ff};
    end else if (idx == rasw_pkg::IDX_BAT_LVL) begin
      rd = {3'h0, lvl_ff};                   // see (RULE10)
    end else begin
      mapped = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers, written at the access edge
  always_comb begin
    nxt_ts     = ts_ff;
    nxt_tvoffs = tvoffs_ff;
    nxt_thr    = thr_ff;
    nxt_irq_en = irq_en_ff;
    nxt_op     = op_ff;
    nxt_sel    = sel_ff;
    nxt_ref    = ref_ff;
    nxt_wexp   = wexp_ff;
    nxt_wman   = wman_ff;
    nxt_prdata = prdata_ff;
    nxt_err    = err_ff;
    // capture read data and error in the setup cycle
    if (psel && !penable) begin
      nxt_prdata = pwrite ? 8'h00 : rd;
      nxt_err    = ~mapped;
    end
    if (wr && mapped) begin
      if (idx == rasw_pkg::IDX_IRQ_EN2) begin
        nxt_irq_en = wd;
      end else if (idx == rasw_pkg::IDX_OP_CTRL) begin
        nxt_op = wd;
      end else if (idx == rasw_pkg::IDX_CONV_CFG) begin
        nxt_sel = wd[6:4];
        nxt_ref = wd[3:2];
      end else if (idx == rasw_pkg::IDX_TS_CTRL) begin
        nxt_ts = wd;
      end else if (idx == rasw_pkg::IDX_TV_OFFS) begin
        nxt_tvoffs = wd;
      end else if (idx == rasw_pkg::IDX_WT_EXP) begin
        nxt_wexp = wd[4:0];
      end else if (idx == rasw_pkg::IDX_WT_MANT_HI) begin
        nxt_wman[15:8] = wd;
      end else if (idx == rasw_pkg::IDX_WT_MANT_LO) begin
        nxt_wman[7:0] = wd;
      end else if (idx == rasw_pkg::IDX_BAT_THR) begin
        nxt_thr = wd[4:0];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ts_ff     <= rasw_pkg::RST_TS_CTRL;   // shift on, see (RULE4)
      tvoffs_ff <= rasw_pkg::RST_TV_OFFS;
      thr_ff    <= rasw_pkg::RST_BAT_THR;
      irq_en_ff <= 8'h00;
      op_ff     <= 8'h00;
      sel_ff    <= 3'h0;
      ref_ff    <= 2'h0;
      wexp_ff   <= rasw_pkg::RST_WT_EXP;
      wman_ff   <= 16'h0000;
      prdata_ff <= 8'h00;
      err_ff    <= 1'b0;
    end else begin
      ts_ff     <= nxt_ts;
      tvoffs_ff <= nxt_tvoffs;
      thr_ff    <= nxt_thr;
      irq_en_ff <= nxt_irq_en;
      op_ff     <= nxt_op;
      sel_ff    <= nxt_sel;
      ref_ff    <= nxt_ref;
      wexp_ff   <= nxt_wexp;
      wman_ff   <= nxt_wman;
      prdata_ff <= nxt_prdata;
      err_ff    <= nxt_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // converter, battery monitor, wake timer and pending flags
  logic        en_bat;       // monitor enabled
  logic        en_wak;       // wake timer enabled
  logic        go;           // software starts a conversion
  logic        meas_end;     // battery sample taken this cycle
  logic        wt_tick;      // one wake unit elapsed
  logic        wt_exp;       // period expired this cycle
  logic        rd_stat;      // status read completes
  logic [8:0]  sum;          // result plus offset
  logic [36:0] pre_lim;      // prescaler terminal count

  assign en_bat  = op_ff[rasw_pkg::BIT_EN_BAT];
  assign en_wak  = op_ff[rasw_pkg::BIT_EN_WAKE];
  assign go      = wr && idx == rasw_pkg::IDX_CONV_CFG && mapped
                   && wd[rasw_pkg::BIT_CONV_GO];
  assign rd_stat = acc && !pwrite && mapped
                   && (idx == rasw_pkg::IDX_IRQ_STAT1
                       || idx == rasw_pkg::IDX_IRQ_STAT2);
  // terminal count 32 * 2^exp - 1 slow ticks per unit, see (RULE17)
  assign pre_lim = (37'h1 << (6'(wexp_ff) + 6'(rasw_pkg::WT_PRE_SHIFT)))
                   - 37'h1;
  assign sum     = {1'b0, conv_sample} + {1'b0, tvoffs_ff};
  assign meas_end = en_bat && bcnt_ff == 24'(rasw_pkg::MEAS_CYC - 1);
  assign wt_tick = wrun_ff && lf_tick && pre_ff >= pre_lim;
  assign wt_exp  = wt_tick && (wtv_ff + 16'h0001) >= wman_ff;

  always_comb begin
    nxt_busy = busy_ff;
    nxt_ccnt = ccnt_ff;
    nxt_cval = cval_ff;
    nxt_bcnt = bcnt_ff;
    nxt_lvl  = lvl_ff;
    nxt_run  = run_ff;
    nxt_wrun = wrun_ff;
    nxt_slp  = sleep_active;
    nxt_pre  = pre_ff;
    nxt_wtv  = wtv_ff;
    nxt_fbat = fbat_ff;
    nxt_fwak = fwak_ff;
    // conversion lasts a fixed time, see (RULE19)
    if (go) begin
      nxt_busy = 1'b1;
      nxt_ccnt = 12'h000;
    end else if (busy_ff) begin
      if (ccnt_ff == 12'(rasw_pkg::CONV_CYC - 1)) begin
        nxt_busy = 1'b0;
        // offset saturates so a hot reading cannot wrap to cold
        if (ts_ff.shift_en) begin
          nxt_cval = sum[8] ? 8'hff : sum[7:0];  // see (RULE5)
        end else begin
          nxt_cval = conv_sample;
        end
      end else begin
        nxt_ccnt = ccnt_ff + 12'h001;
      end
    end
    // battery monitor duty cycle, see (RULE10) (RULE12)
    if (!en_bat) begin
      nxt_bcnt = 24'h000000;
      nxt_run  = 3'h0;
    end else begin
      if (bcnt_ff >= 24'(BAT_PERIOD - 1)) begin
        nxt_bcnt = 24'h000000;
      end else begin
        nxt_bcnt = bcnt_ff + 24'h000001;
      end
      if (meas_end) begin
        nxt_lvl = battery_code;              // see (RULE11)
        if (battery_code < thr_ff) begin
          if (run_ff != rasw_pkg::LOW_RUN_NEEDED) begin
            nxt_run = run_ff + 3'h1;         // see (RULE13)
          end
        end else begin
          nxt_run = 3'h0;
        end
      end
    end
    // wake timer arms on entry to sleep, see (RULE16)
    if (!en_wak) begin
      nxt_wrun = 1'b0;
      nxt_pre  = 37'h0;
      nxt_wtv  = 16'h0000;
    end else if (sleep_active && !slp_ff && !wrun_ff) begin
      nxt_wrun = 1'b1;
      nxt_pre  = 37'h0;
      nxt_wtv  = 16'h0000;
    end else if (wrun_ff && lf_tick) begin
      // counts slow ticks in and out of sleep, see (RULE15)
      if (wt_tick) begin
        nxt_pre = 37'h0;
        nxt_wtv = wt_exp ? 16'h0000 : wtv_ff + 16'h0001;
      end else begin
        nxt_pre = pre_ff + 37'h1;
      end
    end
    // read clears pending flags, a new event wins, see (RULE21)
    if (rd_stat) begin
      nxt_fbat = 1'b0;
      nxt_fwak = 1'b0;
    end
    if (meas_end && battery_code < thr_ff
        && run_ff == rasw_pkg::LOW_RUN_NEEDED - 3'h1) begin
      nxt_fbat = 1'b1;                       // see (RULE8) (RULE13)
    end
    if (wt_exp) begin
      nxt_fwak = 1'b1;                       // see (RULE16)
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy_ff <= 1'b0;
      ccnt_ff <= 12'h000;
      cval_ff <= 8'h00;
      bcnt_ff <= 24'h000000;
      lvl_ff  <= 5'h00;
      run_ff  <= 3'h0;
      wrun_ff <= 1'b0;
      slp_ff  <= 1'b0;
      pre_ff  <= 37'h0;
      wtv_ff  <= 16'h0000;
      fbat_ff <= 1'b0;
      fwak_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
      ccnt_ff <= nxt_ccnt;
      cval_ff <= nxt_cval;
      bcnt_ff <= nxt_bcnt;
      lvl_ff  <= nxt_lvl;
      run_ff  <= nxt_run;
      wrun_ff <= nxt_wrun;
      slp_ff  <= nxt_slp;
      pre_ff  <= nxt_pre;
      wtv_ff  <= nxt_wtv;
      fbat_ff <= nxt_fbat;
      fwak_ff <= nxt_fwak;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs to the analog side and the host
  logic irq_bat;             // enabled low battery pending
  logic irq_wak;             // enabled wake expiry pending

  assign irq_bat = fbat_ff & irq_en_ff[rasw_pkg::BIT_BAT_IRQ];
  assign irq_wak = fwak_ff & irq_en_ff[rasw_pkg::BIT_WAKE_IRQ];
  assign host_interrupt_n = ~(irq_bat | irq_wak);   // see (RULE8) (RULE20)
  assign xtal_enable      = irq_wak;                // see (RULE20)
  // sensor needs no enable bit of its own, see (RULE1)
  assign temp_sensor_enable = (sel_ff == rasw_pkg::SEL_TEMP)
                              | test_bus_temp_sel;
  assign conv_power = busy_ff;
  assign thermal_range        = ts_ff.range;        // see (RULE3)
  assign thermal_shift_enable = ts_ff.shift_en;     // see (RULE4)
  assign sensor_trim  = ts_ff.trim_en ? ts_ff.trim : 2'h0;  // see (RULE6)
  assign bandgap_trim = ts_ff.vbg_trim;
  assign battery_monitor_power = en_bat
                                 && bcnt_ff < 24'(rasw_pkg::MEAS_CYC);
  // slow oscillator on for the monitor in sleep and the armed wake timer, see (RULE14) (RULE15)
  assign lf_osc_enable = (sleep_active & en_bat) | wrun_ff;

endmodule

// ===== test/rasw_assertions.sv
// checker: port-level properties of the aux sensor block
`timescale 1ns/1ns
module rasw_checker (
  // clock and reset
  input wire logic        sys_clk,
  input wire logic        reset,
  // apb slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // sensor, monitor and interrupt outputs
  input wire logic        test_bus_temp_sel,
  input wire logic        temp_sensor_enable,
  input wire logic [1:0]  thermal_range,
  input wire logic        thermal_shift_enable,
  input wire logic        conv_power,
  input wire logic        battery_monitor_power,
  input wire logic        xtal_enable,
  input wire logic        host_interrupt_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // run length of each power window, so its exact length can be asserted
  int bp_cnt_ff;  // battery monitor powered cycles
  int nxt_bp_cnt;
  int cp_cnt_ff;  // converter powered cycles
  int nxt_cp_cnt;

  // counts restart whenever the supply drops
  always_comb begin
    nxt_bp_cnt = battery_monitor_power ? bp_cnt_ff + 1 : 0;
    nxt_cp_cnt = conv_power ? cp_cnt_ff + 1 : 0;
  end

  // reset zeroes both counts
  always_ff @(posedge sys_clk) begin
    bp_cnt_ff <= reset ? 0 : nxt_bp_cnt;
    cp_cnt_ff <= reset ? 0 : nxt_cp_cnt;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_ready_access: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_ready_idle: assert property (!(psel && penable) |-> !pready)
    else $error("pready high outside access phase");
  a_err_qualified: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_temp_bus: assert property (
    test_bus_temp_sel |-> temp_sensor_enable)
    else $error("sensor off while on test bus");
  a_reset_values: assert property (
    $past(reset) |-> host_interrupt_n && thermal_shift_enable
    && thermal_range == 2'h0)
    else $error("wrong values after reset");
  a_bat_window: assert property ($fell(battery_monitor_power)
    |-> bp_cnt_ff == rasw_pkg::MEAS_CYC)
    else $error("battery window length wrong");
  a_conv_window: assert property ($fell(conv_power)
    |-> cp_cnt_ff == rasw_pkg::CONV_CYC)
    else $error("conversion length wrong");
  a_xtal_irq: assert property (
    xtal_enable |-> !host_interrupt_n)
    else $error("crystal on without interrupt");
  a_irq_hold: assert property (
    $rose(host_interrupt_n) |-> $past(psel))
    else $error("interrupt released without access");
endmodule

bind rasw_top rasw_checker u_chk (
  .sys_clk, .reset, .psel, .penable, .prdata, .pready, .pslverr,
  .test_bus_temp_sel, .temp_sensor_enable, .thermal_range,
  .thermal_shift_enable, .conv_power, .battery_monitor_power,
  .xtal_enable, .host_interrupt_n
);

// ===== test/rasw_analog_model.sv
// partner: analog front end with slow oscillator, sensor and battery adc
`timescale 1ns/1ns
module rasw_analog_model #(
  parameter int TICK_DIV = 4  // sys clocks per slow tick, shortened
) (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       reset,
  // levels chosen by the bench
  input wire logic [7:0] smp_set,
  input wire logic [4:0] bat_set,
  // toward the design
  output logic           lf_tick,
  output logic [7:0]     conv_sample,
  output logic [4:0]     battery_code
);
  logic [7:0] div_ff;  // slow clock divider
  logic [7:0] nxt_div;

  // wrap at the divider length
  always_comb begin
    nxt_div = (div_ff == 8'(TICK_DIV - 1)) ? 8'h00 : div_ff + 8'h01;
  end

  // divider register
  always_ff @(posedge sys_clk) begin
    div_ff <= reset ? 8'h00 : nxt_div;
  end

  // rc oscillator runs in sleep as well, so ticks stop only during reset
  assign lf_tick = (div_ff == 8'h00) && !reset;
  // 5-bit battery code and sensor code held at the chosen level
  assign conv_sample = smp_set;
  assign battery_code = bat_set;
endmodule

// ===== test/rasw_bench.sv
// testbench: register, conversion, battery and wake timer scenarios
`timescale 1ns/1ns
module rasw_bench;
  // stimulus and observed signals
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        test_bus_temp_sel = 1'b0;
  logic        sleep_active = 1'b0;
  logic [7:0]  smp_set = 8'h00;
  logic [4:0]  bat_set = 5'h1f;
  logic [31:0] prdata;
  logic        pready, pslverr, lf_tick, conv_power, temp_sensor_enable;
  logic [1:0]  thermal_range, sensor_trim, bandgap_trim;
  logic        thermal_shift_enable, battery_monitor_power, lf_osc_enable;
  logic        xtal_enable, host_interrupt_n;
  logic [7:0]  conv_sample;
  logic [4:0]  battery_code;
  int          miscompares = 0;
  int          n_compared = 0;
  logic [31:0] rs = 32'h3e230969;  // xorshift state

  always #50 sys_clk = ~sys_clk;

  // short battery period keeps the run small
  rasw_top #(.BAT_PERIOD(3000)) dut (
    .sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .conv_sample, .test_bus_temp_sel, .conv_power,
    .temp_sensor_enable, .thermal_range, .thermal_shift_enable,
    .sensor_trim, .bandgap_trim, .battery_code, .battery_monitor_power,
    .sleep_active, .lf_tick, .lf_osc_enable, .xtal_enable,
    .host_interrupt_n);
  rasw_analog_model pm (
    .sys_clk, .reset, .smp_set, .bat_set, .lf_tick, .conv_sample,
    .battery_code);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  // offset only applies with bit5 set, and saturates at full scale
  function automatic logic [7:0] conv_exp(input logic [7:0] s, o, c);
    logic [8:0] t;
    t = {1'b0, s} + {1'b0, o};
    if (!c[5]) return s;
    return t[8] ? 8'hff : t[7:0];
  endfunction
  function automatic logic [1:0] trim_exp(input logic [7:0] c);
    return c[4] ? c[3:2] : 2'h0;
  endfunction

  task automatic finish_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic tmo(input string m);
    chk(1'b0, 1'b1, m);
    finish_test();
  endtask
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [5:0] i,
                     input logic [7:0] d, output logic [7:0] r,
                     output logic e);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {4'h0, i, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k >= 16) tmo("apb wait");
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    apb(1'b1, i, d, r, e);
    chk(e, 1'b0, "write error");
  endtask
  task automatic rd(input logic [5:0] i, output logic [7:0] v);
    logic e;
    apb(1'b0, i, 8'h00, v, e);
  endtask
  task automatic wait_irq(input int lim, output int n);
    n = 0;
    while (host_interrupt_n !== 1'b0 && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= lim) tmo("interrupt wait");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] v, off, smp, ctl;
    logic e;
    int n;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    // reset values, then an unmapped slot
    rd(rasw_pkg::IDX_TS_CTRL, v);
    chk(v, rasw_pkg::RST_TS_CTRL, "ts ctrl reset");
    rd(rasw_pkg::IDX_TV_OFFS, v);
    chk(v, rasw_pkg::RST_TV_OFFS, "offset reset");
    rd(rasw_pkg::IDX_BAT_THR, v);
    chk(v, {3'h0, rasw_pkg::RST_BAT_THR}, "threshold reset");
    rd(rasw_pkg::IDX_WT_EXP, v);
    chk(v, {3'h0, rasw_pkg::RST_WT_EXP}, "exponent reset");
    apb(1'b0, 6'h01, 8'h00, v, e);
    chk(e, 1'b1, "unmapped");
    $display("test reset done");
    // conversions: saturating corner first, then random settings
    for (int i = 0; i < 4; i++) begin
      off = (i == 0) ? 8'hff : 8'(rnd());
      smp = (i == 0) ? 8'h80 : 8'(rnd());
      ctl = 8'(rnd()) | ((i == 0) ? 8'h20 : 8'h00);
      smp_set <= smp;
      wr(rasw_pkg::IDX_TS_CTRL, ctl);
      wr(rasw_pkg::IDX_TV_OFFS, off);
      wr(rasw_pkg::IDX_CONV_CFG, 8'h80);
      @(negedge sys_clk);
      chk(thermal_range, ctl[7:6], "range");
      chk(thermal_shift_enable, ctl[5], "shift");
      chk(sensor_trim, trim_exp(ctl), "trim");
      chk(bandgap_trim, ctl[1:0], "bandgap");
      chk(temp_sensor_enable, 1'b1, "sensor on");
      rd(rasw_pkg::IDX_CONV_CFG, v);
      chk(v[7], 1'b0, "busy flag");
      n = 0;
      do begin
        rd(rasw_pkg::IDX_CONV_CFG, v);
        n++;
      end while (v[7] !== 1'b1 && n < 2000);
      if (n >= 2000) tmo("conversion");
      rd(rasw_pkg::IDX_CONV_VAL, v);
      chk(v, conv_exp(smp, off, ctl), "result");
    end
    // other input selected: sensor follows the test bus only
    wr(rasw_pkg::IDX_CONV_CFG, 8'h10);
    @(negedge sys_clk);
    chk(temp_sensor_enable, 1'b0, "sensor off");
    @(posedge sys_clk);
    test_bus_temp_sel <= 1'b1;
    @(negedge sys_clk);
    chk(temp_sensor_enable, 1'b1, "test bus");
    $display("test conversion done");
    // battery one code below threshold: fourth reading interrupts
    wr(rasw_pkg::IDX_IRQ_EN2, 8'h04);
    bat_set <= 5'h13;
    wr(rasw_pkg::IDX_OP_CTRL, 8'h40);
    repeat (11400) @(posedge sys_clk);
    chk(host_interrupt_n, 1'b1, "early interrupt");
    wait_irq(300, n);
    rd(rasw_pkg::IDX_BAT_LVL, v);
    chk(v, 8'h13, "level");
    rd(rasw_pkg::IDX_IRQ_STAT2, v);
    chk(v, 8'h04, "battery flag");
    rd(rasw_pkg::IDX_IRQ_STAT1, v);
    chk(v, 8'h00, "status one");
    @(negedge sys_clk);
    chk(host_interrupt_n, 1'b1, "released");
    @(posedge sys_clk);
    sleep_active <= 1'b1;
    @(negedge sys_clk);
    chk(lf_osc_enable, 1'b1, "slow osc");
    @(posedge sys_clk);
    sleep_active <= 1'b0;
    // disable between windows so no window is cut short
    n = 0;
    while (battery_monitor_power !== 1'b0 && n < 3000) begin
      @(posedge sys_clk);
      n++;
    end
    wr(rasw_pkg::IDX_OP_CTRL, 8'h00);
    $display("test battery done");
    // wake timer: exponent 0, mantissa 2 gives 2*32 slow ticks
    wr(rasw_pkg::IDX_WT_EXP, 8'h00);
    wr(rasw_pkg::IDX_WT_MANT_LO, 8'h02);
    wr(rasw_pkg::IDX_IRQ_EN2, 8'h08);
    wr(rasw_pkg::IDX_OP_CTRL, 8'h20);
    @(posedge sys_clk);
    sleep_active <= 1'b1;
    wait_irq(600, n);
    chk(n >= 248 && n <= 266, 1'b1, "wake period");
    @(negedge sys_clk);
    chk(xtal_enable, 1'b1, "crystal on");
    rd(rasw_pkg::IDX_IRQ_STAT2, v);
    chk(v, 8'h08, "wake flag");
    rd(rasw_pkg::IDX_WT_VAL_HI, v);
    chk(v, 8'h00, "count high");
    rd(rasw_pkg::IDX_WT_VAL_LO, v);
    chk(v, 8'h00, "count low");
    @(negedge sys_clk);
    chk({host_interrupt_n, xtal_enable}, 2'b10, "cleared");
    wr(rasw_pkg::IDX_OP_CTRL, 8'h00);
    sleep_active <= 1'b0;
    $display("test wake done");
    finish_test();
  end
endmodule
